// file: cwc_pkg.sv
// Purpose: constants for the 8-bit waveform timer
// Assumes: plain register port, 3-bit register index
// Notes:   offsets are register indices
package cwc_pkg;
  localparam logic [2:0] ADDR_CTRL_A  = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B  = 3'h1;
  localparam logic [2:0] ADDR_COUNT   = 3'h2;
  localparam logic [2:0] ADDR_CMP_A   = 3'h3;
  localparam logic [2:0] ADDR_CMP_B   = 3'h4;
  localparam logic [2:0] ADDR_FLAGS   = 3'h5;
  localparam logic [2:0] ADDR_DIR     = 3'h6;
  localparam int COM_A_POS = 6;
  localparam int COM_B_POS = 4;
  localparam int FOC_A_POS = 7;
  localparam int FOC_B_POS = 6;
  localparam int WGM_HI_POS = 3;
  localparam int FLG_TOV_POS = 0;
  localparam int FLG_A_POS = 1;
  localparam int FLG_B_POS = 2;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0f;
  localparam logic [7:0] VAL_MAX    = 8'hff;
  localparam logic [7:0] VAL_BOTTOM = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_64   = 10'h03f;
  localparam logic [9:0] DIV_256  = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;
endpackage

// file: cwc_timer.sv
// Purpose: 8-bit timer/counter with two compare channels and waveforms
// Assumes: one clock clk_sys, sync active-high reset, ext pin async
// Notes:   flag register cleared by writing one; service strobes clear too
// Overview of operation
// RQ1 - nonzero B output mode takes the pin; driver enabled by direction bit
// RQ2 - non-PWM B modes: off, toggle, clear, set on match
// RQ3 - fast PWM B: 01 reserved, 10 clear match set bottom, 11 inverse
// RQ4 - phase PWM B: 10 clear up-match set down-match, 11 inverse
// RQ5 - PWM with compare equal TOP and upper bit: act at TOP instead
// RQ6 - reserved control bits read zero; software writes zeros
// RQ7 - 3-bit waveform mode split over both control registers; 4,6 reserved
// RQ8 - modes 0,1,3 TOP is 0xff; modes 2,5,7 TOP is compare A
// RQ9 - compare writes immediate non-PWM, at TOP phase, at BOTTOM fast
// RQ10 - overflow flag at MAX modes 0,2,3; BOTTOM 1,5; TOP mode 7
// RQ11 - force strobe applies channel action in non-PWM modes, reads zero
// RQ12 - force strobe sets no flag and never clears the counter
// RQ13 - software writes zero force bits in PWM modes
// RQ14 - clock select: stop, div 1, 8, 64, 256, 1024
// RQ15 - select 110 counts falling, 111 rising external pin edges
// RQ16 - external pin counts even when configured as output
// RQ17 - counter readable, writable; write blocks next compare match
// RQ18 - compare registers matched with counter each timer tick
// RQ19 - flags set by events, cleared by service or writing one
// RQ20 - counter synchronous to system clock; tick is an enable
// RQ21 - reset clears outputs, stops counter, zeroes control fields
`timescale 1ns/1ps
module cwc_timer (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_count_pin,
  input  wire logic       svc_ovf,
  input  wire logic       svc_match_a,
  input  wire logic       svc_match_b,
  output logic            chan_a_wave_out,
  output logic            chan_a_wave_oe,
  output logic            chan_b_wave_out,
  output logic            chan_b_wave_oe,
  output logic            overflow_flag,
  output logic            match_a_flag,
  output logic            match_b_flag
);
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cnt;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [1:0] dir;
    logic       down;
    logic       blk;
    logic       oc_a;
    logic       oc_b;
    logic       tov;
    logic       ocf_a;
    logic       ocf_b;
    logic [9:0] pre;
    logic [2:0] pin_s;
    logic       pin_lv;
    logic [7:0] rdata;
    logic       oe_a;
    logic       oe_b;
  } cwc_state_s;

  cwc_state_s s_q;
  cwc_state_s s_d;

  logic [2:0] mode;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [2:0] csel;
  logic       fast;
  logic       phase;
  logic       pwm;
  logic [7:0] top;
  logic       tick;
  logic       ext_rise;
  logic       ext_fall;
  logic       m_a;
  logic       m_b;
  logic       at_top;
  logic       at_bot;
  logic       wr_cnt;
  logic       foc_a;
  logic       foc_b;

  // applies one channel's action to its latch
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic fastm, input logic phasem,
                                     input logic match, input logic dn,
                                     input logic bot, input logic tp,
                                     input logic cmp_top);
    logic r;
    r = cur;
    if (!fastm && !phasem) begin
      if (match) begin
        case (com)
          2'h1:    r = ~cur; // RQ2
          2'h2:    r = 1'b0; // RQ2
          2'h3:    r = 1'b1; // RQ2
          default: r = cur;
        endcase
      end
    end else if (com[1]) begin
      if (cmp_top) begin
        if (tp)
          r = fastm ? com[0] : (com[0] ^ dn); // RQ5
      end else if (fastm) begin
        if (match)
          r = com[0]; // RQ3
        else if (bot)
          r = ~com[0]; // RQ3
      end else if (match) begin
        r = dn ? ~com[0] : com[0]; // RQ4
      end
    end
    return r;
  endfunction

  always_comb begin
    mode  = {s_q.ctrl_b[cwc_pkg::WGM_HI_POS], s_q.ctrl_a[1:0]}; // RQ7
    com_a = s_q.ctrl_a[cwc_pkg::COM_A_POS +: 2];
    com_b = s_q.ctrl_a[cwc_pkg::COM_B_POS +: 2];
    csel  = s_q.ctrl_b[2:0];
    fast  = (mode == 3'h3) || (mode == 3'h7);
    phase = (mode == 3'h1) || (mode == 3'h5);
    pwm   = fast || phase;
    top   = (mode == 3'h2 || mode == 3'h5 || mode == 3'h7) ?
            s_q.cmp_a : cwc_pkg::VAL_MAX; // RQ8
    // edge counts once second and third stage agree
    ext_rise = s_q.pin_s[2] && s_q.pin_s[1] && !s_q.pin_lv;
    ext_fall = !s_q.pin_s[2] && !s_q.pin_s[1] && s_q.pin_lv;
    case (csel) // RQ14
      3'h1:    tick = 1'b1;
      3'h2:    tick = (s_q.pre[2:0] == cwc_pkg::DIV_8[2:0]);
      3'h3:    tick = (s_q.pre[5:0] == cwc_pkg::DIV_64[5:0]);
      3'h4:    tick = (s_q.pre[7:0] == cwc_pkg::DIV_256[7:0]);
      3'h5:    tick = (s_q.pre == cwc_pkg::DIV_1024);
      3'h6:    tick = ext_fall; // RQ15 RQ16
      3'h7:    tick = ext_rise; // RQ15 RQ16
      default: tick = 1'b0;
    endcase
    wr_cnt = reg_wr && (reg_addr == cwc_pkg::ADDR_COUNT);
    m_a = tick && !s_q.blk && (s_q.cnt == s_q.cmp_a); // RQ17 RQ18
    m_b = tick && !s_q.blk && (s_q.cnt == s_q.cmp_b); // RQ18
    at_top = tick && (s_q.cnt == top);
    at_bot = tick && (s_q.cnt == cwc_pkg::VAL_BOTTOM);
    foc_a = reg_wr && (reg_addr == cwc_pkg::ADDR_CTRL_B) && !pwm &&
            reg_wdata[cwc_pkg::FOC_A_POS]; // RQ11
    foc_b = reg_wr && (reg_addr == cwc_pkg::ADDR_CTRL_B) && !pwm &&
            reg_wdata[cwc_pkg::FOC_B_POS]; // RQ11

    s_d = s_q;
    s_d.pin_s = {s_q.pin_s[1:0], ext_count_pin};
    if (s_q.pin_s[2] == s_q.pin_s[1])
      s_d.pin_lv = s_q.pin_s[2];
    s_d.pre = (csel == 3'h0) ? 10'h000 : s_q.pre + 10'h001;
    if (tick)
      s_d.blk = 1'b0;

    // counting sequence, enable only
    if (tick) begin // RQ20
      if (phase) begin
        if (!s_q.down && s_q.cnt >= top) begin
          s_d.down = 1'b1;
          s_d.cnt  = s_q.cnt - 8'h01;
        end else if (s_q.down && s_q.cnt == cwc_pkg::VAL_BOTTOM) begin
          s_d.down = 1'b0;
          s_d.cnt  = s_q.cnt + 8'h01;
        end else begin
          s_d.cnt = s_q.down ? s_q.cnt - 8'h01 : s_q.cnt + 8'h01;
        end
      end else begin
        s_d.down = 1'b0;
        // force strobe is not a match here
        if (s_q.cnt == top) // RQ12
          s_d.cnt = cwc_pkg::VAL_BOTTOM;
        else
          s_d.cnt = s_q.cnt + 8'h01;
      end
    end

    // compare buffer update
    if (!pwm) begin // RQ9
      s_d.cmp_a = s_q.cmp_a_buf;
      s_d.cmp_b = s_q.cmp_b_buf;
    end else if ((phase && at_top) ||
                 (fast && s_d.cnt == cwc_pkg::VAL_BOTTOM && tick)) begin
      s_d.cmp_a = s_q.cmp_a_buf; // RQ9
      s_d.cmp_b = s_q.cmp_b_buf; // RQ9
    end

    // waveform latches
    s_d.oc_a = wave_next(s_q.oc_a, com_a, fast, phase, m_a || foc_a,
                         s_q.down, at_bot, at_top, s_q.cmp_a == top);
    s_d.oc_b = wave_next(s_q.oc_b, com_b, fast, phase, m_b || foc_b,
                         s_q.down, at_bot, at_top, s_q.cmp_b == top);
    s_d.oe_a = (com_a != 2'h0) && s_q.dir[0];
    s_d.oe_b = (com_b != 2'h0) && s_q.dir[1]; // RQ1

    // flags: set wins over clear
    if (reg_wr && reg_addr == cwc_pkg::ADDR_FLAGS) begin // RQ19
      if (reg_wdata[cwc_pkg::FLG_TOV_POS])
        s_d.tov = 1'b0;
      if (reg_wdata[cwc_pkg::FLG_A_POS])
        s_d.ocf_a = 1'b0;
      if (reg_wdata[cwc_pkg::FLG_B_POS])
        s_d.ocf_b = 1'b0;
    end
    if (svc_ovf)
      s_d.tov = 1'b0;
    if (svc_match_a)
      s_d.ocf_a = 1'b0;
    if (svc_match_b)
      s_d.ocf_b = 1'b0;
    if (m_a)
      s_d.ocf_a = 1'b1; // RQ19
    if (m_b)
      s_d.ocf_b = 1'b1; // RQ19
    if ((phase && at_bot) || (mode == 3'h7 && at_top) ||
        (!phase && mode != 3'h7 && tick && s_q.cnt == cwc_pkg::VAL_MAX))
      s_d.tov = 1'b1; // RQ10

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        cwc_pkg::ADDR_CTRL_A: s_d.ctrl_a = reg_wdata & cwc_pkg::CTRL_A_MASK;
        cwc_pkg::ADDR_CTRL_B: s_d.ctrl_b = reg_wdata & cwc_pkg::CTRL_B_MASK;
        cwc_pkg::ADDR_COUNT: begin
          s_d.cnt = reg_wdata; // RQ17
          s_d.blk = 1'b1; // RQ17
        end
        cwc_pkg::ADDR_CMP_A: s_d.cmp_a_buf = reg_wdata;
        cwc_pkg::ADDR_CMP_B: s_d.cmp_b_buf = reg_wdata;
        cwc_pkg::ADDR_DIR:   s_d.dir = reg_wdata[1:0];
        default: ;
      endcase
    end

    // read port, reserved bits zero
    s_d.rdata = cwc_pkg::RESET_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        cwc_pkg::ADDR_CTRL_A: s_d.rdata = s_q.ctrl_a; // RQ6
        cwc_pkg::ADDR_CTRL_B: s_d.rdata = s_q.ctrl_b; // RQ6 RQ11
        cwc_pkg::ADDR_COUNT:  s_d.rdata = s_q.cnt;
        cwc_pkg::ADDR_CMP_A:  s_d.rdata = s_q.cmp_a_buf;
        cwc_pkg::ADDR_CMP_B:  s_d.rdata = s_q.cmp_b_buf;
        cwc_pkg::ADDR_FLAGS:  s_d.rdata = {5'h00, s_q.ocf_b, s_q.ocf_a, s_q.tov};
        cwc_pkg::ADDR_DIR:    s_d.rdata = {6'h00, s_q.dir};
        default:              s_d.rdata = cwc_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      s_q <= '0; // RQ21
    else
      s_q <= s_d;
  end

  always_comb begin
    reg_rdata       = s_q.rdata;
    chan_a_wave_out = s_q.oc_a;
    chan_b_wave_out = s_q.oc_b;
    chan_a_wave_oe  = s_q.oe_a;
    chan_b_wave_oe  = s_q.oe_b;
    overflow_flag   = s_q.tov;
    match_a_flag    = s_q.ocf_a;
    match_b_flag    = s_q.ocf_b;
  end
endmodule

// file: cwc_timer_props.sv
// Purpose: port checks for cwc_timer
// Assumes: bound to the top module, one clock
// Notes:   read data registered, one cycle after the strobe
`timescale 1ns/1ps
module cwc_props (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       svc_ovf,
  input wire logic       chan_b_wave_out,
  input wire logic       chan_b_wave_oe,
  input wire logic       overflow_flag,
  input wire logic       match_a_flag,
  input wire logic       match_b_flag
);
  logic clr0;
  assign clr0 = reg_wr && reg_addr == cwc_pkg::ADDR_FLAGS && reg_wdata[0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    !chan_b_wave_out && !overflow_flag && !match_b_flag && !chan_b_wave_oe)
    else $error("outputs not cleared by reset");
  flag_clear_a: assert property ($fell(overflow_flag) |->
    $past(svc_ovf) || $past(rst) || $past(clr0))
    else $error("overflow flag fell without a clear");
  oe_mode_off_a: assert property (reg_wr && reg_addr == cwc_pkg::ADDR_CTRL_A
    && reg_wdata[5:4] == 2'b00 ##1 !reg_wr |=> !chan_b_wave_oe)
    else $error("pin enabled with output mode off");
  oe_dir_off_a: assert property (reg_wr && reg_addr == cwc_pkg::ADDR_DIR
    && !reg_wdata[1] ##1 !reg_wr |=> !chan_b_wave_oe)
    else $error("pin enabled with direction input");
  ctla_resv_a: assert property (reg_rd && reg_addr == cwc_pkg::ADDR_CTRL_A
    |=> reg_rdata[3:2] == 2'b00) else $error("control a reserved bits set");
  ctlb_force_a: assert property (reg_rd && reg_addr == cwc_pkg::ADDR_CTRL_B
    |=> reg_rdata[7:4] == 4'h0) else $error("control b upper bits set");
  flag_read_a: assert property (reg_rd && reg_addr == cwc_pkg::ADDR_FLAGS
    |=> reg_rdata == {5'h00, $past(match_b_flag), $past(match_a_flag),
    $past(overflow_flag)}) else $error("flag read differs from flags");
  cover property (reg_wr && reg_addr == cwc_pkg::ADDR_CTRL_B);
  cover property ($rose(match_b_flag));
  cover property ($rose(overflow_flag));
endmodule
bind cwc_timer cwc_props u_props (.*);

// file: cwc_timer_bench.sv
// Purpose: self-checking bench for cwc_timer
// Assumes: register port, one clock at 40 MHz
// Notes:   short directed scenarios
`timescale 1ns/1ps
module cwc_timer_bench;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       ext_count_pin = 1'b0;
  logic       svc_ovf = 1'b0;
  logic       svc_match_a = 1'b0;
  logic       svc_match_b = 1'b0;
  logic [7:0] reg_rdata;
  logic       chan_a_wave_out, chan_a_wave_oe, chan_b_wave_out;
  logic       chan_b_wave_oe, overflow_flag, match_a_flag, match_b_flag;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         n, d;
  logic [3:0] hi_nib [4] = '{4'hd, 4'hb, 4'h6, 4'h1};
  logic [3:0] exp_b      = 4'b1011;
  always #12.5 clk_sys = ~clk_sys;
  cwc_timer dut (.*);
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      repeat (4) @(posedge clk_sys);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_count_pin <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(cwc_pkg::ADDR_CTRL_A, 8'hff);
    rd(cwc_pkg::ADDR_CTRL_A, 8'hf3);
    wr(cwc_pkg::ADDR_CTRL_A, 8'h00);
    wr(cwc_pkg::ADDR_CTRL_B, 8'hf0);
    rd(cwc_pkg::ADDR_CTRL_B, 8'h00);
    wr(cwc_pkg::ADDR_COUNT, 8'h5a);
    rd(cwc_pkg::ADDR_COUNT, 8'h5a);
    wr(cwc_pkg::ADDR_CMP_B, 8'ha5);
    rd(cwc_pkg::ADDR_CMP_B, 8'ha5);
    wr(cwc_pkg::ADDR_DIR, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(cwc_pkg::ADDR_CTRL_A, {hi_nib[i], 4'h0});
      wr(cwc_pkg::ADDR_CTRL_B, 8'h40);
      repeat (2) @(posedge clk_sys);
      #1 chk("force", {15'h0, exp_b[i]}, {15'h0, chan_b_wave_out});
      chk("oe,flag", 16'h4, {13'h0, chan_b_wave_oe, match_b_flag,
          chan_a_wave_oe});
    end
    wr(cwc_pkg::ADDR_CTRL_A, 8'h20);
    for (int s = 1; s < 4; s++) begin
      wr(cwc_pkg::ADDR_CTRL_B, 8'h00);
      wr(cwc_pkg::ADDR_COUNT, 8'h00);
      wr(cwc_pkg::ADDR_FLAGS, 8'h07);
      wr(cwc_pkg::ADDR_CTRL_B, s[7:0]);
      n = 0;
      while (overflow_flag !== 1'b1 && n < 20000) begin
        @(posedge clk_sys);
        n++;
      end
      d = (s == 1) ? 1 : (s == 2) ? 8 : 64;
      chk("span", 16'h1, {15'h0, n >= 255 * d - 8 && n <= 256 * d + 8});
    end
    chk("match b", 16'h2, {14'h0, match_b_flag, chan_b_wave_out});
    wr(cwc_pkg::ADDR_CTRL_B, 8'h00);
    wr(cwc_pkg::ADDR_FLAGS, 8'h01);
    svc_match_b <= 1'b1;
    @(posedge clk_sys);
    svc_match_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk("clear", 16'h0, {14'h0, match_b_flag, overflow_flag});
    wr(cwc_pkg::ADDR_COUNT, 8'h00);
    wr(cwc_pkg::ADDR_CTRL_B, 8'h07);
    pulse(5);
    rd(cwc_pkg::ADDR_COUNT, 8'h05);
    wr(cwc_pkg::ADDR_CTRL_B, 8'h06);
    pulse(3);
    rd(cwc_pkg::ADDR_COUNT, 8'h08);
    wr(cwc_pkg::ADDR_CTRL_A, 8'h02);
    wr(cwc_pkg::ADDR_CMP_A, 8'h09);
    wr(cwc_pkg::ADDR_COUNT, 8'h00);
    wr(cwc_pkg::ADDR_FLAGS, 8'h07);
    wr(cwc_pkg::ADDR_CTRL_B, 8'h01);
    repeat (300) @(posedge clk_sys);
    #1 chk("ctc flags", 16'h1, {14'h0, overflow_flag, match_a_flag});
    wr(cwc_pkg::ADDR_CTRL_B, 8'h00);
    wr(cwc_pkg::ADDR_CTRL_A, 8'hc2);
    wr(cwc_pkg::ADDR_CTRL_B, 8'h80);
    wr(cwc_pkg::ADDR_DIR, 8'h03);
    repeat (2) @(posedge clk_sys);
    #1 chk("chan a", 16'h3, {14'h0, chan_a_wave_out, chan_a_wave_oe});
    wr(cwc_pkg::ADDR_CMP_B, 8'h40);
    wr(cwc_pkg::ADDR_COUNT, 8'h30);
    wr(cwc_pkg::ADDR_CTRL_A, 8'h23);
    wr(cwc_pkg::ADDR_CTRL_B, 8'h01);
    repeat (100) @(posedge clk_sys);
    #1 chk("fast clr", 16'h0, {15'h0, chan_b_wave_out});
    repeat (120) @(posedge clk_sys);
    #1 chk("fast set", 16'h1, {15'h0, chan_b_wave_out});
    wrap_up();
  end
endmodule
